// file: design/siohad_consts.svh
// Constants for the host address decoder
`ifndef SIOHAD_CONSTS_SVH
`define SIOHAD_CONSTS_SVH
`define SIOHAD_CFG_PORT_A 16'h03F0
`define SIOHAD_CFG_PORT_B 16'h0370
`define SIOHAD_IDE_EXCL_A 16'h03F7
`define SIOHAD_IDE_EXCL_B 16'h0377
`define SIOHAD_IDE_DATA_PORT 16'h01F0
`define SIOHAD_ECP_OFFSET 16'h0400
`define SIOHAD_FDC_HOLE 3'h6
`define SIOHAD_IDE_ALT_OFF 3'h6
`define SIOHAD_BASE_RESET 16'h0000
`endif

// file: design/siohad_pkg.sv
// Types for the host address decoder
`default_nettype none
package siohad_pkg;
   typedef enum logic [1:0] {
      SIOHAD_PP_SPP,
      SIOHAD_PP_EPP,
      SIOHAD_PP_ECP
   } siohad_pp_mode_t;
endpackage
`default_nettype wire

// file: design/siohad_match_if.sv
// Carrier between the decoder and a block-window matcher
`default_nettype none
interface siohad_match_if;
   logic [15:0] addr;
   logic [15:0] base;
   logic [3:0] size_log2;
   logic hit;
   modport owner (output addr, output base, output size_log2, input hit);
   modport matcher (input addr, input base, input size_log2, output hit);
endinterface
`default_nettype wire

// file: design/siohad_match.sv
// Aligned window match of an address against a base
`default_nettype none
module siohad_match (
   siohad_match_if.matcher m
);
   wire [15:0] mask = 16'hFFFF << m.size_log2;
   assign m.hit = ((m.addr ^ m.base) & mask) == 16'h0000;
endmodule
`default_nettype wire

// file: design/siohad_top.sv
// Host address decoder with power-good gating
`default_nettype none
`include "siohad_consts.svh"
module siohad_top (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic power_good_in_i,
   input wire logic [15:0] addr_i,
   input wire logic aen_i,
   input wire logic ior_n_i,
   input wire logic iow_n_i,
   input wire logic cfg_alt_port_i,
   input wire logic cfg_mode_i,
   input wire logic cfg_wr_i,
   input wire logic [2:0] cfg_sel_i,
   input wire logic [15:0] cfg_data_i,
   input wire logic [5:0] cfg_enable_i,
   input wire logic [1:0] pp_mode_i,
   output logic game_port_select_n_o,
   output logic game_port_select_oe_o,
   output logic ide_enable_n_o,
   output logic ide_enable_oe_o,
   output logic ide_wide_o,
   output logic cfg_port_sel_o,
   output logic fdc_sel_o,
   output logic fdc_ro_sel_o,
   output logic ser1_sel_o,
   output logic ser2_sel_o,
   output logic pp_sel_o,
   output logic selects_oe_o
);
   // Base slots: 0 fdc, 1 ser1, 2 ser2, 3 pp, 4 ide1, 5 ide2, 6 game
   localparam int NBASE = 7;
   logic [15:0] base [NBASE];
   logic [5:0] enable;
   logic [1:0] pp_mode;
   localparam logic [3:0] WIN [NBASE] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h0};
   wire [NBASE-1:0] hit;
   wire ecp_hit;

   // Register writes only in config mode; held while power-good is low
   wire cfg_we = cfg_wr_i && cfg_mode_i && power_good_in_i;
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         enable <= 6'h00;
         pp_mode <= 2'h0;
      end else if (cfg_we) begin
         enable <= cfg_enable_i;
         pp_mode <= pp_mode_i;
      end
   end
   for (genvar i = 0; i < NBASE; i++) begin : g_base
      siohad_match_if mi ();
      assign mi.addr = addr_i;
      assign mi.base = base[i];
      assign mi.size_log2 = WIN[i];
      assign hit[i] = mi.hit;
      siohad_match u_match (.m(mi));
      always_ff @(posedge core_clk_i) begin
         if (!reset_n_i) begin
            base[i] <= `SIOHAD_BASE_RESET;
         end else if (cfg_we && cfg_sel_i == 3'(i)) begin
            base[i] <= cfg_data_i;
         end
      end
   end
   siohad_match_if me ();
   assign me.addr = addr_i;
   assign me.base = 16'(base[3] + `SIOHAD_ECP_OFFSET);
   assign me.size_log2 = 4'h2;
   assign ecp_hit = me.hit;
   siohad_match u_ecp (.m(me));

   wire pio = !aen_i;
   wire any_rw = !ior_n_i || !iow_n_i;
   wire [2:0] off = addr_i[2:0];
   wire [15:0] pair_addr = {addr_i[15:1], 1'h0};
   wire cfg_addr = cfg_alt_port_i ? (pair_addr == `SIOHAD_CFG_PORT_B)
                                  : (pair_addr == `SIOHAD_CFG_PORT_A);
   wire next_cfg = pio && cfg_addr && !iow_n_i;
   wire fdc_ok = pio && enable[0] && hit[0] && off != `SIOHAD_FDC_HOLE;
   wire fdc_ro = off[2:1] == 2'h0;
   wire next_fdc_ro = fdc_ok && fdc_ro && !ior_n_i && !cfg_mode_i;
   wire next_fdc = fdc_ok && (!fdc_ro || next_fdc_ro) && any_rw;
   wire next_ser1 = pio && enable[1] && hit[1] && any_rw;
   wire next_ser2 = pio && enable[2] && hit[2] && any_rw;
   wire pp_lo = hit[3] && !off[2];
   wire pp_epp = hit[3] && off[2] && pp_mode == 2'(siohad_pkg::SIOHAD_PP_EPP);
   wire pp_ecp = ecp_hit && pp_mode == 2'(siohad_pkg::SIOHAD_PP_ECP);
   wire next_pp = pio && enable[3] && (pp_lo || pp_epp || pp_ecp) && any_rw;
   wire ide_excl = addr_i == `SIOHAD_IDE_EXCL_A || addr_i == `SIOHAD_IDE_EXCL_B;
   wire ide_hit = hit[4] || (hit[5] && off == `SIOHAD_IDE_ALT_OFF);
   wire next_ide = pio && enable[4] && ide_hit && !ide_excl && any_rw;
   wire next_wide = next_ide && addr_i == `SIOHAD_IDE_DATA_PORT;
   wire next_game = pio && enable[5] && hit[6] && any_rw;

   // Low-active selects idle high through reset
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         game_port_select_n_o <= 1'h1;
      end else begin
         game_port_select_n_o <= !next_game;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         ide_enable_n_o <= 1'h1;
         ide_wide_o <= 1'h0;
      end else begin
         ide_enable_n_o <= !next_ide;
         ide_wide_o <= next_wide;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         cfg_port_sel_o <= 1'h0;
      end else begin
         cfg_port_sel_o <= next_cfg;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         fdc_sel_o <= 1'h0;
         fdc_ro_sel_o <= 1'h0;
      end else begin
         fdc_sel_o <= next_fdc;
         fdc_ro_sel_o <= next_fdc_ro;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         ser1_sel_o <= 1'h0;
         ser2_sel_o <= 1'h0;
      end else begin
         ser1_sel_o <= next_ser1;
         ser2_sel_o <= next_ser2;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         pp_sel_o <= 1'h0;
      end else begin
         pp_sel_o <= next_pp;
      end
   end
   // Output enables follow power-good one cycle late
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         game_port_select_oe_o <= 1'h0;
      end else begin
         game_port_select_oe_o <= power_good_in_i;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         ide_enable_oe_o <= 1'h0;
      end else begin
         ide_enable_oe_o <= power_good_in_i;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         selects_oe_o <= 1'h0;
      end else begin
         selects_oe_o <= power_good_in_i;
      end
   end

   chk_game_select: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      aen_i |=> game_port_select_n_o) else $error("game select during dma");
   chk_ide_excl: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (addr_i == `SIOHAD_IDE_EXCL_A || addr_i == `SIOHAD_IDE_EXCL_B) |=> ide_enable_n_o)
      else $error("ide hit excluded port");
   chk_oe_power_good_in: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      !power_good_in_i |=> !selects_oe_o && !ide_enable_oe_o && !game_port_select_oe_o)
      else $error("outputs driven without power good");
   chk_oe_power: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      power_good_in_i |=> selects_oe_o && ide_enable_oe_o && game_port_select_oe_o)
      else $error("outputs released with power good");
   chk_cfg_lock: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      !cfg_mode_i |=> $stable(enable) && $stable(pp_mode))
      else $error("config changed outside mode");
   chk_base_lock: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      !cfg_mode_i |=> $stable(base[0]) && $stable(base[3]))
      else $error("base changed outside mode");
   chk_power_good_in_hold: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      !power_good_in_i |=> $stable(enable) && $stable(base[1]))
      else $error("state lost without power good");
   chk_fdc_status: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      cfg_mode_i |=> !fdc_ro_sel_o) else $error("status read in config mode");
   chk_cfg_write: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      iow_n_i |=> !cfg_port_sel_o) else $error("config port without write");
   chk_cfg_alt: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (cfg_alt_port_i && pair_addr == `SIOHAD_CFG_PORT_A) |=> !cfg_port_sel_o)
      else $error("config port at unselected pair");
   chk_ide_enable: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      !enable[4] |=> ide_enable_n_o) else $error("ide select while disabled");
   chk_ide_alt: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (hit[5] && !hit[4] && addr_i[2:0] != `SIOHAD_IDE_ALT_OFF) |=> ide_enable_n_o)
      else $error("ide second base beyond one port");
   chk_wide_ide: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      ide_wide_o |-> !ide_enable_n_o) else $error("wide path without ide");
   chk_wide_port: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      ide_wide_o |-> $past(addr_i) == `SIOHAD_IDE_DATA_PORT)
      else $error("wide path off the data port");
   chk_fdc_hole: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (addr_i[2:0] == `SIOHAD_FDC_HOLE && hit[0]) |=> !fdc_sel_o)
      else $error("fdc hole decoded");
   chk_fdc_ro_sel: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      fdc_ro_sel_o |-> fdc_sel_o) else $error("status select outside fdc");
   chk_pp_upper: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (pp_mode == 2'(siohad_pkg::SIOHAD_PP_SPP) && hit[3] && addr_i[2]) |=> !pp_sel_o)
      else $error("upper parallel offsets in base mode");
   chk_dma_quiet: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      aen_i |=> !fdc_sel_o && !ser1_sel_o && !ser2_sel_o && !pp_sel_o)
      else $error("block select during dma");
   chk_cfg_dma: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      aen_i |=> !cfg_port_sel_o && ide_enable_n_o) else $error("select during dma");
   chk_blocks_off: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (enable[3:0] == 4'h0) |=> !fdc_sel_o && !ser1_sel_o && !ser2_sel_o && !pp_sel_o)
      else $error("select from disabled block");
   cov_game: cover property (@(posedge core_clk_i) !game_port_select_n_o);
   cov_ide_wide: cover property (@(posedge core_clk_i) ide_wide_o);
   cov_pp: cover property (@(posedge core_clk_i) pp_sel_o);
   cov_cfg_port: cover property (@(posedge core_clk_i) cfg_port_sel_o);
   cov_ecp: cover property (@(posedge core_clk_i)
      pp_sel_o && pp_mode == 2'(siohad_pkg::SIOHAD_PP_ECP));
endmodule
`default_nettype wire

// file: bench/siohad_host_model.sv
// Host bus model that issues I/O cycles to the decoder
`default_nettype none
module siohad_host_model (
   input wire logic clk_i,
   output logic [15:0] addr_o,
   output logic aen_o,
   output logic ior_n_o,
   output logic iow_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      addr_o = 16'hFFFF;
      aen_o = 1'b0;
      ior_n_o = 1'b1;
      iow_n_o = 1'b1;
   end
   // Programmed cycle when dma is low, DMA cycle otherwise
   task automatic cycle(input logic [15:0] a, input logic rd, input logic dma);
      @(posedge clk_i);
      #1;
      addr_o = a;
      aen_o = dma;
      ior_n_o = ~rd;
      iow_n_o = rd;
      @(posedge clk_i);
      #1;
   endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the host address decoder
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, pg = 1, alt = 1, mode = 0, wr = 0;
   logic [2:0] sel = 3'h0;
   logic [15:0] data = 16'h0000, addr;
   logic [5:0] en = 6'h00;
   logic [1:0] pm = 2'h0;
   logic aen, ior_n, iow_n, gs_n, gs_oe, ide_n, ide_oe, wide, cps, fs, fro, s1, s2, pps, oe;
   int n_mismatch = 0, tests_run = 0;
   always #25 clk = ~clk;
   siohad_host_model u_host (.clk_i(clk), .addr_o(addr), .aen_o(aen), .ior_n_o(ior_n),
      .iow_n_o(iow_n));
   siohad_top u_dut (.core_clk_i(clk), .reset_n_i(rst_n), .power_good_in_i(pg),
      .addr_i(addr), .aen_i(aen), .ior_n_i(ior_n), .iow_n_i(iow_n), .cfg_alt_port_i(alt),
      .cfg_mode_i(mode), .cfg_wr_i(wr), .cfg_sel_i(sel), .cfg_data_i(data),
      .cfg_enable_i(en), .pp_mode_i(pm), .game_port_select_n_o(gs_n),
      .game_port_select_oe_o(gs_oe), .ide_enable_n_o(ide_n), .ide_enable_oe_o(ide_oe),
      .ide_wide_o(wide), .cfg_port_sel_o(cps), .fdc_sel_o(fs), .fdc_ro_sel_o(fro),
      .ser1_sel_o(s1), .ser2_sel_o(s2), .pp_sel_o(pps), .selects_oe_o(oe));
   task automatic chk(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: output %b, expected %b", $time, got, exp);
      end
   endtask
   task automatic cfg(input logic [2:0] s, input logic [15:0] d, input logic m);
      @(posedge clk);
      #1;
      mode = m;
      wr = 1;
      sel = s;
      data = d;
      @(posedge clk);
      #1;
      wr = 0;
      mode = 0;
   endtask
   task automatic io(input logic [15:0] a, input logic rd, input logic dma);
      u_host.cycle(a, rd, dma);
   endtask
   task automatic t_map;
      io(16'h0002, 1, 0);
      chk(fs, 0);
      en = 6'h3F;
      cfg(3'h0, 16'h03F0, 1);
      cfg(3'h1, 16'h02F8, 1);
      cfg(3'h2, 16'h03E8, 1);
      cfg(3'h3, 16'h0378, 1);
      cfg(3'h4, 16'h01F0, 1);
      cfg(3'h5, 16'h03F0, 1);
      cfg(3'h6, 16'h0201, 1);
      io(16'h03F6, 1, 0);
      chk(fs, 0);
      chk(ide_n, 0);
      io(16'h03F1, 1, 0);
      chk(fro, 1);
      io(16'h03F1, 0, 0);
      chk(fs, 0);
      io(16'h02FF, 1, 0);
      chk(s1, 1);
      io(16'h03E8, 0, 0);
      chk(s2, 1);
      io(16'h0201, 1, 0);
      chk(gs_n, 0);
      io(16'h0201, 1, 1);
      chk(gs_n, 1);
      io(16'h01F0, 1, 0);
      chk(wide, 1);
      io(16'h01F1, 1, 0);
      chk(wide, 0);
   endtask
   task automatic t_cfg;
      io(16'h0371, 0, 0);
      chk(cps, 1);
      io(16'h0370, 1, 0);
      chk(cps, 0);
      alt = 0;
      io(16'h03F0, 0, 0);
      chk(cps, 1);
      mode = 1;
      io(16'h03F0, 1, 0);
      chk(fro, 0);
      mode = 0;
      en = 6'h00;
      cfg(3'h0, 16'h0100, 0);
      en = 6'h3F;
      io(16'h03F2, 1, 1);
      chk(fs, 0);
      io(16'h03F2, 1, 0);
      chk(fs, 1);
   endtask
   task automatic t_pp;
      io(16'h037C, 1, 0);
      chk(pps, 0);
      pm = 2'h1;
      cfg(3'h3, 16'h0378, 1);
      io(16'h037C, 1, 0);
      chk(pps, 1);
      pm = 2'h2;
      cfg(3'h3, 16'h0378, 1);
      io(16'h077B, 1, 0);
      chk(pps, 1);
      io(16'h037C, 1, 0);
      chk(pps, 0);
   endtask
   task automatic t_ide_pg;
      cfg(3'h4, 16'h0370, 1);
      io(16'h0377, 1, 0);
      chk(ide_n, 1);
      io(16'h0376, 1, 0);
      chk(ide_n, 0);
      cfg(3'h4, 16'h03F0, 1);
      io(16'h03F7, 1, 0);
      chk(ide_n, 1);
      en = 6'h2F;
      cfg(3'h4, 16'h0370, 1);
      io(16'h0376, 1, 0);
      chk(ide_n, 1);
      pg = 0;
      en = 6'h00;
      cfg(3'h1, 16'h0100, 1);
      io(16'h02FF, 1, 0);
      chk(oe, 0);
      chk(gs_oe, 0);
      chk(ide_oe, 0);
      en = 6'h2F;
      pg = 1;
      io(16'h02FF, 1, 0);
      chk(s1, 1);
      chk(oe, 1);
      chk(gs_oe, 1);
      chk(ide_oe, 1);
   endtask
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      tally_and_finish;
   end
   initial begin
      repeat (5) @(posedge clk);
      #1 rst_n = 1;
      t_map;
      t_cfg;
      t_pp;
      t_ide_pg;
      tally_and_finish;
   end
endmodule
`default_nettype wire
